/* verilog/tach_defs.svh */
`ifndef TACH_DEFS_SVH
`define TACH_DEFS_SVH
`define TACH_CFG_OFFSET 8'h04
`define TACH_DUTY_OFFSET 8'h06
`define TACH_ONOFF_OFFSET 8'h01
`define TACH_CFG_RESET 8'h01
`define TACH_DUTY_RESET 7'h00
`define TACH_ON_RESET 1'b1
`define TACH_RETRY_BIT 7
`define TACH_MODE_HI 6
`define TACH_MODE_LO 5
`define TACH_SINK_BIT 4
`define TACH_INRUSH_BIT 3
`define TACH_ONOFF_BIT 1
`define TACH_DUTY_MAX 7'h64
`define TACH_CLK_HZ 100000000
`define TACH_PWM_STEPS 100
// Cycles per duty step for 100 Hz and 1 kHz PWM
`define TACH_PWM100_STEP (`TACH_CLK_HZ / (100 * `TACH_PWM_STEPS))
`define TACH_PWM1K_STEP (`TACH_CLK_HZ / (1000 * `TACH_PWM_STEPS))
// Half periods of the fixed oscillator
`define TACH_OSC_HALF(f) (`TACH_CLK_HZ / (2 * (f)))
`endif

/* verilog/tach_pkg.sv */
package tach_pkg;
	typedef enum logic [1:0] {
		MODE_DIVIDED = 2'b00,
		MODE_OSC = 2'b01,
		MODE_DRIVER = 2'b10,
		MODE_DRIVER_ALT = 2'b11
	} tach_mode_e;
endpackage

/* verilog/tach_output_mode_control.sv */
`timescale 1ns/100ps
`include "tach_defs.svh"
// Functional notes
// RULE1: Retry after fault only when bit7 set
// RULE2: Bits 6:5 select mode; 11 equals 10
// RULE3: Bit4 enables open-load sink, else flag zero
// RULE4: Bit3 picks short or in-rush blanking
// RULE5: Bits 4:0 meaning depends on mode
// RULE6: Divider code 1..31 is N, 0 is 32
// RULE7: Reset config is divide-by-1, no retry
// RULE8: Bits 2:0 select eight oscillator frequencies
// RULE9: Host avoids the 100 kHz code
// RULE10: Bits 1:0 select none, 100 Hz, 1 kHz PWM
// RULE11: Duty 7-bit percent, 100..127 full on
// RULE12: On/off bit 1 switches output, resets on
// RULE13: Overcurrent shuts output off, not limiting
// RULE14: Count crank edges, one period per N
// RULE15: PWM high for programmed percent of period
module tach_output_mode_control (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] cfg_rdata,
	output logic [6:0] duty_rdata,
	output logic onoff_rdata,
	input wire logic crank_pulse_in,
	input wire logic overcurrent_in,
	input wire logic open_load_in,
	output logic tach_output_pin,
	output logic open_load_sink_en,
	output logic inrush_blank_sel,
	output logic oc_shutdown,
	output logic open_load
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] cfg_reg, cfg_next;
	logic [6:0] duty_reg, duty_next;
	logic on_reg, on_next;
	logic div_restart;
	tach_pkg::tach_mode_e mode;
	logic driver_mode;

	always_comb begin
		cfg_next = cfg_reg;
		duty_next = duty_reg;
		on_next = on_reg;
		div_restart = 1'b0;
		if (reg_wr) begin
			if (reg_addr == `TACH_CFG_OFFSET) begin
				cfg_next = reg_wdata;
				div_restart = 1'b1; // RULE14
			end
			if (reg_addr == `TACH_DUTY_OFFSET) begin
				duty_next = reg_wdata[6:0];
			end
			if (reg_addr == `TACH_ONOFF_OFFSET) begin
				on_next = reg_wdata[`TACH_ONOFF_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_reg <= `TACH_CFG_RESET; // RULE7
			duty_reg <= `TACH_DUTY_RESET;
			on_reg <= `TACH_ON_RESET; // RULE12
		end else begin
			cfg_reg <= cfg_next;
			duty_reg <= duty_next;
			on_reg <= on_next;
		end
	end

	assign mode = tach_pkg::tach_mode_e'(cfg_reg[`TACH_MODE_HI:`TACH_MODE_LO]); // RULE2 RULE5
	assign driver_mode = cfg_reg[`TACH_MODE_HI]; // RULE2
	assign cfg_rdata = cfg_reg;
	assign duty_rdata = duty_reg;
	assign onoff_rdata = on_reg;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] crank_sync_reg, crank_sync_next;
	logic [2:0] oc_sync_reg, oc_sync_next;
	logic [2:0] ol_sync_reg, ol_sync_next;
	logic crank_state_reg, crank_state_next;
	logic oc_state_reg, oc_state_next;
	logic ol_state_reg, ol_state_next;
	logic crank_rise;

	always_comb begin
		crank_sync_next = {crank_sync_reg[1:0], crank_pulse_in};
		oc_sync_next = {oc_sync_reg[1:0], overcurrent_in};
		ol_sync_next = {ol_sync_reg[1:0], open_load_in};
		crank_state_next = (crank_sync_reg[1] == crank_sync_reg[2]) ? crank_sync_reg[2] : crank_state_reg;
		oc_state_next = (oc_sync_reg[1] == oc_sync_reg[2]) ? oc_sync_reg[2] : oc_state_reg;
		ol_state_next = (ol_sync_reg[1] == ol_sync_reg[2]) ? ol_sync_reg[2] : ol_state_reg;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			crank_sync_reg <= 3'h0;
			oc_sync_reg <= 3'h0;
			ol_sync_reg <= 3'h0;
			crank_state_reg <= 1'b0;
			oc_state_reg <= 1'b0;
			ol_state_reg <= 1'b0;
		end else begin
			crank_sync_reg <= crank_sync_next;
			oc_sync_reg <= oc_sync_next;
			ol_sync_reg <= ol_sync_next;
			crank_state_reg <= crank_state_next;
			oc_state_reg <= oc_state_next;
			ol_state_reg <= ol_state_next;
		end
	end

	assign crank_rise = crank_state_next & ~crank_state_reg;

	// ****************************************
	// Divided crank pulse
	// ****************************************
	logic [5:0] div_n;
	logic [4:0] div_cnt_reg, div_cnt_next;
	logic div_out_reg, div_out_next;

	assign div_n = (cfg_reg[4:0] == 5'h00) ? 6'h20 : {1'b0, cfg_reg[4:0]}; // RULE6

	// Output toggles every N/2 edges; odd N gives a slightly uneven duty
	always_comb begin
		div_cnt_next = div_cnt_reg;
		div_out_next = div_out_reg;
		if (div_restart) begin
			div_cnt_next = 5'h00; // RULE14
			div_out_next = 1'b0;
		end else if (crank_rise) begin
			if ({1'b0, div_cnt_reg} == div_n - 6'h01) begin
				div_cnt_next = 5'h00;
				div_out_next = 1'b1; // RULE14
			end else begin
				div_cnt_next = div_cnt_reg + 5'h01;
				if ({1'b0, div_cnt_reg} + 6'h01 >= (div_n >> 1)) begin
					div_out_next = 1'b0;
				end
			end
			if (div_n == 6'h01) begin
				div_out_next = 1'b1;
			end
		end else if (div_n == 6'h01) begin
			div_out_next = crank_state_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_cnt_reg <= 5'h00;
			div_out_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			div_out_reg <= div_out_next;
		end
	end

	// ****************************************
	// Fixed oscillator
	// ****************************************
	logic [22:0] osc_half;
	logic [22:0] osc_cnt_reg, osc_cnt_next;
	logic osc_out_reg, osc_out_next;

	always_comb begin
		case (cfg_reg[2:0]) // RULE8
			3'h0: osc_half = 23'(`TACH_OSC_HALF(10));
			3'h1: osc_half = 23'(`TACH_OSC_HALF(100));
			3'h2: osc_half = 23'(`TACH_OSC_HALF(1000));
			3'h3: osc_half = 23'(`TACH_OSC_HALF(5000));
			3'h4: osc_half = 23'(`TACH_OSC_HALF(10000));
			3'h5: osc_half = 23'(`TACH_OSC_HALF(20000));
			3'h6: osc_half = 23'(`TACH_OSC_HALF(40000));
			default: osc_half = 23'(`TACH_OSC_HALF(100000));
		endcase
	end

	always_comb begin
		osc_cnt_next = osc_cnt_reg + 23'h000001;
		osc_out_next = osc_out_reg;
		if (div_restart) begin
			osc_cnt_next = 23'h000000;
		end else if (osc_cnt_reg >= osc_half - 23'h000001) begin
			osc_cnt_next = 23'h000000;
			osc_out_next = ~osc_out_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			osc_cnt_reg <= 23'h000000;
			osc_out_reg <= 1'b0;
		end else begin
			osc_cnt_reg <= osc_cnt_next;
			osc_out_reg <= osc_out_next;
		end
	end

	// ****************************************
	// Driver PWM
	// ****************************************
	logic [13:0] pwm_pre_reg, pwm_pre_next;
	logic [6:0] pwm_step_reg, pwm_step_next;
	logic [13:0] pwm_pre_max;
	logic [6:0] duty_eff;
	logic pwm_on;
	logic pwm_active;

	assign pwm_active = cfg_reg[1] ^ cfg_reg[0]; // RULE10
	assign pwm_pre_max = cfg_reg[0] ? 14'(`TACH_PWM100_STEP - 1) : 14'(`TACH_PWM1K_STEP - 1); // RULE10
	assign duty_eff = (duty_reg > `TACH_DUTY_MAX) ? `TACH_DUTY_MAX : duty_reg; // RULE11
	assign pwm_on = pwm_step_reg < duty_eff; // RULE15

	always_comb begin
		pwm_pre_next = pwm_pre_reg + 14'h0001;
		pwm_step_next = pwm_step_reg;
		if (div_restart) begin
			pwm_pre_next = 14'h0000;
			pwm_step_next = 7'h00;
		end else if (pwm_pre_reg >= pwm_pre_max) begin
			pwm_pre_next = 14'h0000;
			pwm_step_next = (pwm_step_reg == 7'(`TACH_PWM_STEPS - 1)) ? 7'h00 : pwm_step_reg + 7'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pwm_pre_reg <= 14'h0000;
			pwm_step_reg <= 7'h00;
		end else begin
			pwm_pre_reg <= pwm_pre_next;
			pwm_step_reg <= pwm_step_next;
		end
	end

	// ****************************************
	// Output and overcurrent shutdown
	// ****************************************
	logic shut_reg, shut_next;
	logic drive_req;
	logic out_next;
	logic out_reg;

	always_comb begin
		case (mode)
			tach_pkg::MODE_DIVIDED: drive_req = div_out_reg;
			tach_pkg::MODE_OSC: drive_req = osc_out_reg;
			default: drive_req = pwm_active ? pwm_on : 1'b1; // RULE15
		endcase
		drive_req = drive_req & on_reg; // RULE12
		shut_next = shut_reg;
		if (oc_state_reg & out_reg) begin
			shut_next = 1'b1; // RULE13
		end else if (cfg_reg[`TACH_RETRY_BIT] & ~oc_state_reg) begin
			shut_next = 1'b0; // RULE1
		end else if (~on_reg) begin
			shut_next = 1'b0;
		end
		out_next = drive_req & ~shut_next; // RULE13
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			shut_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			shut_reg <= shut_next;
			out_reg <= out_next;
		end
	end

	assign tach_output_pin = out_reg;
	assign oc_shutdown = shut_reg;
	assign open_load_sink_en = driver_mode & cfg_reg[`TACH_SINK_BIT]; // RULE3
	assign open_load = open_load_sink_en & ol_state_reg; // RULE3
	assign inrush_blank_sel = driver_mode & cfg_reg[`TACH_INRUSH_BIT]; // RULE4
endmodule

/* sim/tach_props.sv */
`timescale 1ns/100ps
// ****
// Checks
// ****
module tach_props (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [7:0] cfg_rdata,
	input wire logic onoff_rdata,
	input wire logic tach_output_pin,
	input wire logic open_load_sink_en,
	input wire logic oc_shutdown,
	input wire logic open_load
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence s_off;
		!onoff_rdata [*2];
	endsequence
	sequence s_on;
		(cfg_rdata[6] && cfg_rdata[1:0] inside {2'b00, 2'b11} && onoff_rdata && !oc_shutdown) [*2];
	endsequence
	a_cfg_write: assert property (reg_wr && reg_addr == 8'h04 |=> cfg_rdata == $past(reg_wdata))
		else $error("cfg write lost");
	a_reset_vals: assert property (disable iff (1'b0) srst |=> cfg_rdata == 8'h01 && onoff_rdata && !oc_shutdown)
		else $error("bad reset state");
	a_no_retry: assert property (oc_shutdown && !cfg_rdata[7] && onoff_rdata && !reg_wr |=> oc_shutdown)
		else $error("shutdown cleared");
	a_oc_off: assert property (oc_shutdown [*2] |-> !tach_output_pin)
		else $error("on in shutdown");
	a_off_low: assert property (s_off |-> !tach_output_pin)
		else $error("on while off");
	a_drv_on: assert property (s_on |-> tach_output_pin)
		else $error("driver not on");
	a_sink_mode: assert property (open_load_sink_en == (cfg_rdata[6] && cfg_rdata[4]))
		else $error("sink enable");
	a_ol_forced: assert property (!open_load_sink_en [*2] |-> !open_load)
		else $error("open load flag");
endmodule

/* sim/tach_load_model.sv */
`timescale 1ns/100ps
// ****
// Load
// ****
module tach_load_model (
	input wire logic tach_output_pin,
	input wire logic short_cmd,
	input wire logic open_cmd,
	output logic overcurrent_in,
	output logic open_load_in
);
	assign overcurrent_in = short_cmd & tach_output_pin;
	assign open_load_in = open_cmd & ~tach_output_pin;
endmodule

/* sim/tach_output_mode_control_tb.sv */
`timescale 1ns/100ps
// ****
// Bench
// ****
module tach_output_mode_control_tb;
	typedef struct {logic [7:0] cfg; logic [1:0] exp;} row_s;
	logic sys_clk = 0, srst = 1, reg_wr = 0, crank_pulse_in = 0, short_cmd = 0, open_cmd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cfg_rdata;
	logic [6:0] duty_rdata;
	logic onoff_rdata, tach_output_pin, open_load_sink_en, inrush_blank_sel, oc_shutdown, open_load;
	logic overcurrent_in, open_load_in, p0;
	int mismatches = 0, n_checks = 0, cyc = 0;
	row_s rows[5] = '{
		'{8'h1F, 2'b00},
		'{8'h38, 2'b00},
		'{8'h50, 2'b10},
		'{8'h68, 2'b01},
		'{8'h5B, 2'b11}
	};
	tach_output_mode_control dut_u (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .cfg_rdata, .duty_rdata,
		.onoff_rdata, .crank_pulse_in, .overcurrent_in, .open_load_in, .tach_output_pin, .open_load_sink_en,
		.inrush_blank_sel, .oc_shutdown, .open_load);
	tach_load_model load_u (.tach_output_pin, .short_cmd, .open_cmd, .overcurrent_in, .open_load_in);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		tk(1);
		reg_wr = 0;
		tk(1);
	endtask
	// Counts output periods over a run of crank periods
	task automatic div(input logic [7:0] c, input int e, input int x);
		int r = 0;
		logic p;
		wr(8'h04, c);
		p = tach_output_pin;
		repeat (2 * e) begin
			crank_pulse_in = ~crank_pulse_in;
			repeat (8) begin
				tk(1);
				r += int'(tach_output_pin & ~p);
				p = tach_output_pin;
			end
		end
		chk(r, x);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		tk(20);
		srst = 0;
		tk(1);
		chk(cfg_rdata, 8'h01);
		chk({duty_rdata, onoff_rdata, tach_output_pin, oc_shutdown}, 16'h0004);
		$display("reset done");
		foreach (rows[i]) begin
			wr(8'h04, rows[i].cfg);
			chk(cfg_rdata, rows[i].cfg);
			chk({open_load_sink_en, inrush_blank_sel}, rows[i].exp);
		end
		wr(8'h02, 8'hAA);
		chk(cfg_rdata, 8'h5B);
		wr(8'h06, 8'h7F);
		chk(duty_rdata, 7'h7F);
		$display("table done");
		wr(8'h04, 8'h43);
		chk(tach_output_pin, 1);
		wr(8'h01, 8'h00);
		chk(tach_output_pin, 0);
		wr(8'h01, 8'h02);
		short_cmd = 1;
		tk(10);
		chk({oc_shutdown, tach_output_pin}, 2'b10);
		short_cmd = 0;
		tk(20);
		chk(oc_shutdown, 1);
		wr(8'h04, 8'hC3);
		tk(10);
		chk({oc_shutdown, tach_output_pin}, 2'b01);
		$display("fault done");
		wr(8'h04, 8'h40);
		wr(8'h01, 8'h00);
		open_cmd = 1;
		tk(8);
		chk(open_load, 0);
		wr(8'h04, 8'h50);
		tk(8);
		chk(open_load, 1);
		open_cmd = 0;
		wr(8'h01, 8'h02);
		div(8'h02, 4, 2);
		div(8'h00, 64, 2);
		$display("divider done");
		wr(8'h04, 8'h42);
		tk(1100);
		chk(tach_output_pin, 1);
		wr(8'h06, 8'h01);
		wr(8'h04, 8'h42);
		tk(500);
		chk(tach_output_pin, 1);
		tk(600);
		chk(tach_output_pin, 0);
		wr(8'h04, 8'h41);
		tk(1100);
		chk(tach_output_pin, 1);
		tk(9000);
		chk(tach_output_pin, 0);
		$display("pwm done");
		wr(8'h04, 8'h26);
		p0 = tach_output_pin;
		tk(1200);
		chk(tach_output_pin, p0);
		tk(100);
		chk(tach_output_pin, !p0);
		tk(1250);
		chk(tach_output_pin, p0);
		$display("osc done");
		srst = 1;
		tk(2);
		srst = 0;
		tk(1);
		chk(cfg_rdata, 8'h01);
		chk({duty_rdata, onoff_rdata, oc_shutdown}, 9'h002);
		$display("reset again done");
		end_sim();
	end
endmodule
bind tach_output_mode_control tach_props chk_u (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .cfg_rdata,
	.onoff_rdata, .tach_output_pin, .open_load_sink_en, .oc_shutdown, .open_load);
